// [design/ckh_regs.svh]
// frame codes, status words, frame layout and slot counts for the card key host
// assumes byte-wide command frames to a contactless coupler
`ifndef CKH_REGS_SVH
`define CKH_REGS_SVH

`define CKH_CLA 8'hff
`define CKH_INS_LOAD 8'h82
`define CKH_INS_AUTH 8'h86
`define CKH_INS_READ 8'hb0
`define CKH_INS_WRITE 8'hd6

`define CKH_LOC_VOL 8'h00
`define CKH_LOC_NVM 8'h20
`define CKH_KIND_A 8'h60
`define CKH_KIND_B 8'h61
`define CKH_KEY_LEN 8'h06
`define CKH_AUTH_LEN 8'h05
`define CKH_AUTH_B0 8'h01
`define CKH_AUTH_B1 8'h00

`define CKH_HDR_BYTES 5'h05
`define CKH_LOAD_BYTES 5'h0b
`define CKH_AUTH_BYTES 5'h0a
`define CKH_SECTOR_BLOCK_LEN 8'h10
`define CKH_TYPE2_BLOCK_LEN 8'h04

`define CKH_SW_OK 16'h9000
`define CKH_SW1_WRONG_LE 8'h6c
`define CKH_SW_REFUSED 16'h6985

`define CKH_NVM_BASE 6'h08
`define CKH_SLOTS 40
`define CKH_BIG_SECTOR_BLOCK 8'h80
`define CKH_BIG_SECTOR_BASE 6'h20

`endif

// [design/ckh_pkg.sv]
// types shared by the card key host modules
// assumes ckh_regs.svh for the numeric codes
`default_nettype none

package ckh_pkg;

  typedef enum logic [1:0] {
    ckh_op_load = 2'h0,
    ckh_op_auth = 2'h1,
    ckh_op_read = 2'h2,
    ckh_op_write = 2'h3
  } ckh_op_e;

  typedef struct packed {
    ckh_op_e op;
    logic [7:0] p1;
    logic [7:0] p2;
    logic [7:0] blk;
    logic [7:0] key_loc;
    logic [7:0] key_idx;
    logic [7:0] len;
    logic [47:0] key;
    logic [127:0] wdata;
  } ckh_req_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
    logic last;
  } ckh_byte_s;

endpackage : ckh_pkg

`default_nettype wire

// [design/ckh_resp.sv]
// response splitter: forwards data bytes, keeps the final two bytes as status
// assumes response bytes arrive on core_clk with a last marker, no back-pressure
`timescale 1ns/1ps
`default_nettype none

module ckh_resp (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // response bytes from the coupler
  input wire ckh_pkg::ckh_byte_s rx,
  // data and status out
  output logic rd_valid,
  output logic [7:0] rd_data,
  output logic sw_valid,
  output logic [15:0] sw
);
  import ckh_pkg::*;

  logic [7:0] old_reg;
  logic [7:0] new_reg;
  logic [1:0] cnt_reg;

  // two-byte delay line so status bytes never leak out as data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      old_reg <= 8'h00;
      new_reg <= 8'h00;
      cnt_reg <= 2'h0;
    end else if (rx.valid) begin
      old_reg <= new_reg;
      new_reg <= rx.data;
      if (rx.last) begin
        cnt_reg <= 2'h0;
      end else if (cnt_reg != 2'h2) begin
        cnt_reg <= cnt_reg + 2'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rd_valid <= 1'b0;
      rd_data <= 8'h00;
    end else begin
      rd_valid <= rx.valid && (cnt_reg == 2'h2);
      rd_data <= old_reg;
    end
  end

  // status is the last two bytes of the frame; a one-byte frame gives status 00 then that byte
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sw_valid <= 1'b0;
      sw <= 16'h0000;
    end else begin
      sw_valid <= rx.valid && rx.last;
      if (rx.valid && rx.last) begin
        sw <= {(cnt_reg == 2'h0) ? 8'h00 : new_reg, rx.data};
      end
    end
  end

endmodule : ckh_resp

`default_nettype wire

// [design/ckh_host.sv]
// card key host: issues key-store, authenticate, block read and block write frames
// assumes the coupler shares core_clk and takes bytes on a valid/ready handshake
//
// Notes on behaviour
// - authenticate frame is FF 86 00 00 with five data bytes
// - host stores a key before an authenticate refers to it
// - host authenticates only when the card uses sector authentication
// - authenticate data byte0 is 01, byte1 00, byte2 the block number
// - block read is FF B0 with P1 address high, P2 address low
// - sector cards need authentication, renewed on every sector change
// - type 2 tags: P2 block, P1 sector or 00
// - block write is FF D6 with address in P1 P2 and Lc the length
// - sector cards write exactly 16 bytes
// - type 2 tags write exactly 4 bytes
`include "ckh_regs.svh"
`timescale 1ns/1ps
`default_nettype none

module ckh_host (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // user request
  input wire logic start_i,
  input wire ckh_pkg::ckh_req_s req_i,
  // card facts from the selection stage
  input wire logic card_is_sector_i,
  input wire logic card_is_type2_i,
  input wire logic card_new_i,
  // user answer
  output logic busy_o,
  output logic done_o,
  output logic refused_o,
  output logic [15:0] status_o,
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  // command bytes to the coupler
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  // response bytes from the coupler
  input wire ckh_pkg::ckh_byte_s rx_i
);
  import ckh_pkg::*;

  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_send = 3'b010,
    st_wait = 3'b100
  } ckh_state_e;

  ckh_state_e state_reg;
  ckh_req_s req_reg;
  logic [4:0] idx_reg;
  logic retried_reg;
  logic [`CKH_SLOTS-1:0] loaded_reg;
  logic auth_ok_reg;
  logic [5:0] auth_sec_reg;
  logic sw_valid;
  logic [15:0] sw;
  logic refuse_now;
  logic [4:0] frame_len;
  logic [6:0] load_slot;
  logic [6:0] auth_slot;
  logic [6:0] run_slot;
  logic tx_fire;
  logic retry_now;

  // volatile slots 0-7, non-volatile from CKH_NVM_BASE; bit 6 marks a usable index
  function automatic logic [6:0] store_slot(input logic [7:0] loc, input logic [7:0] idx);
    logic [6:0] r;
    r = 7'h00;
    if (loc == `CKH_LOC_VOL && idx[7:5] == 3'h0 && idx[3:2] == 2'h0) begin
      r = {1'b1, 3'h0, idx[4], idx[1:0]};
    end else if (loc == `CKH_LOC_NVM && idx[7:5] == 3'h0) begin
      r = {1'b1, `CKH_NVM_BASE + {1'b0, idx[4:0]}};
    end
    return r;
  endfunction : store_slot

  function automatic logic [6:0] key_slot(input logic [7:0] kind, input logic [7:0] idx);
    logic [6:0] r;
    logic b;
    r = 7'h00;
    b = (kind == `CKH_KIND_B);
    if (kind == `CKH_KIND_A || kind == `CKH_KIND_B) begin
      if (idx[7:2] == 6'h00) begin
        r = {1'b1, 3'h0, b, idx[1:0]};
      end else if (idx[7:4] == 4'h2) begin
        r = {1'b1, `CKH_NVM_BASE + {1'b0, b, idx[3:0]}};
      end
    end else begin
      r = store_slot(kind, idx);
    end
    return r;
  endfunction : key_slot

  // large sectors start at block 80h and hold 16 blocks
  function automatic logic [5:0] sector_of(input logic [7:0] blk);
    logic [5:0] r;
    if (blk < `CKH_BIG_SECTOR_BLOCK) begin
      r = blk[7:2];
    end else begin
      r = `CKH_BIG_SECTOR_BASE + {2'h0, blk[6:3] >> 1};
    end
    return r;
  endfunction : sector_of

  function automatic logic [7:0] frame_byte(input ckh_req_s q, input logic [4:0] i);
    logic [7:0] r;
    logic [4:0] k;
    r = 8'h00;
    k = i - `CKH_HDR_BYTES;
    case (i)
      5'h00: r = `CKH_CLA;
      5'h01: begin
        case (q.op)
          ckh_op_load: r = `CKH_INS_LOAD;
          ckh_op_auth: r = `CKH_INS_AUTH;
          ckh_op_read: r = `CKH_INS_READ;
          default: r = `CKH_INS_WRITE;
        endcase
      end
      5'h02: r = (q.op == ckh_op_auth) ? 8'h00 : q.p1;
      5'h03: r = (q.op == ckh_op_auth) ? 8'h00 : q.p2;
      5'h04: begin
        case (q.op)
          ckh_op_load: r = `CKH_KEY_LEN;
          ckh_op_auth: r = `CKH_AUTH_LEN;
          default: r = q.len;
        endcase
      end
      default: begin
        case (q.op)
          ckh_op_load: r = q.key[8'(47 - 8 * k) -: 8];
          ckh_op_auth: begin
            case (k)
              5'h00: r = `CKH_AUTH_B0;
              5'h01: r = `CKH_AUTH_B1;
              5'h02: r = q.blk;
              5'h03: r = q.key_loc;
              default: r = q.key_idx;
            endcase
          end
          default: r = q.wdata[8'(127 - 8 * k) -: 8];
        endcase
      end
    endcase
    return r;
  endfunction : frame_byte

  ckh_resp u_resp (
    .core_clk(core_clk),
    .arst_n(arst_n),
    .rx(rx_i),
    .rd_valid(rd_valid_o),
    .rd_data(rd_data_o),
    .sw_valid(sw_valid),
    .sw(sw)
  );

  assign load_slot = store_slot(req_reg.p1, req_reg.p2);
  assign auth_slot = key_slot(req_i.key_loc, req_i.key_idx);
  assign run_slot = key_slot(req_reg.key_loc, req_reg.key_idx);
  assign tx_fire = tx_valid_o && tx_ready_i;
  assign retry_now = state_reg == st_wait && sw_valid && req_reg.op == ckh_op_read &&
                     sw[15:8] == `CKH_SW1_WRONG_LE && !retried_reg;

  always_comb begin
    case (req_reg.op)
      ckh_op_load: frame_len = `CKH_LOAD_BYTES;
      ckh_op_auth: frame_len = `CKH_AUTH_BYTES;
      ckh_op_read: frame_len = `CKH_HDR_BYTES;
      default: frame_len = `CKH_HDR_BYTES + req_reg.len[4:0];
    endcase
  end

  // requests the coupler must never see
  always_comb begin
    refuse_now = 1'b0;
    case (req_i.op)
      ckh_op_auth: begin
        refuse_now = !card_is_sector_i;
        if (auth_slot[6] && !loaded_reg[auth_slot[5:0]]) begin
          refuse_now = 1'b1;
        end
      end
      ckh_op_read, ckh_op_write: begin
        if (card_is_sector_i && (!auth_ok_reg || req_i.p1 != 8'h00 ||
            sector_of(req_i.p2) != auth_sec_reg)) begin
          refuse_now = 1'b1;
        end
        if (req_i.op == ckh_op_write) begin
          if (card_is_sector_i && req_i.len != `CKH_SECTOR_BLOCK_LEN) begin
            refuse_now = 1'b1;
          end else if (card_is_type2_i && req_i.len != `CKH_TYPE2_BLOCK_LEN) begin
            refuse_now = 1'b1;
          end else if (req_i.len == 8'h00 || req_i.len > `CKH_SECTOR_BLOCK_LEN) begin
            refuse_now = 1'b1;
          end
        end
      end
      default: refuse_now = 1'b0;
    endcase
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= st_idle;
    end else begin
      case (state_reg)
        st_idle: if (start_i && !refuse_now) state_reg <= st_send;
        st_send: if (tx_fire && tx_last_o) state_reg <= st_wait;
        st_wait: begin
          if (retry_now) begin
            state_reg <= st_send;
          end else if (sw_valid) begin
            state_reg <= st_idle;
          end
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      req_reg <= '0;
      retried_reg <= 1'b0;
    end else if (state_reg == st_idle && start_i) begin
      req_reg <= req_i;
      retried_reg <= 1'b0;
    end else if (retry_now) begin
      req_reg.len <= sw[7:0];
      retried_reg <= 1'b1;
    end
  end

  // byte sender: first byte is always the class byte, so it needs no latched request
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tx_valid_o <= 1'b0;
      tx_data_o <= 8'h00;
      tx_last_o <= 1'b0;
      idx_reg <= 5'h00;
    end else if ((state_reg == st_idle && start_i && !refuse_now) || retry_now) begin
      tx_valid_o <= 1'b1;
      tx_data_o <= `CKH_CLA;
      tx_last_o <= 1'b0;
      idx_reg <= 5'h00;
    end else if (tx_fire) begin
      if (tx_last_o) begin
        tx_valid_o <= 1'b0;
        tx_last_o <= 1'b0;
      end else begin
        tx_data_o <= frame_byte(req_reg, idx_reg + 5'h01);
        tx_last_o <= (idx_reg + 5'h02) == frame_len;
        idx_reg <= idx_reg + 5'h01;
      end
    end
  end

  // key and session tracking from answers
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      loaded_reg <= '0;
      auth_ok_reg <= 1'b0;
      auth_sec_reg <= 6'h00;
    end else begin
      if (card_new_i) begin
        auth_ok_reg <= 1'b0;
      end
      if (state_reg == st_wait && sw_valid) begin
        if (req_reg.op == ckh_op_load && sw == `CKH_SW_OK && load_slot[6]) begin
          loaded_reg[load_slot[5:0]] <= 1'b1;
        end
        if (req_reg.op == ckh_op_auth) begin
          auth_ok_reg <= (sw == `CKH_SW_OK);
          auth_sec_reg <= sector_of(req_reg.blk);
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      done_o <= 1'b0;
      refused_o <= 1'b0;
      status_o <= 16'h0000;
      busy_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      busy_o <= (state_reg == st_idle) ? (start_i && !refuse_now) : !(state_reg == st_wait &&
                sw_valid && !retry_now);
      if (state_reg == st_idle && start_i && refuse_now) begin
        done_o <= 1'b1;
        refused_o <= 1'b1;
        status_o <= `CKH_SW_REFUSED;
      end else if (state_reg == st_wait && sw_valid && !retry_now) begin
        done_o <= 1'b1;
        refused_o <= 1'b0;
        status_o <= sw;
      end
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  sequence idle_start;
    state_reg == st_idle && start_i;
  endsequence

  sequence auth_b0_sent;
    tx_fire && req_reg.op == ckh_op_auth && idx_reg == 5'h05;
  endsequence

  refuse_quiet_a: assert property (idle_start ##0 refuse_now |=> done_o && refused_o && !tx_valid_o)
    else $error("refused request did not complete quietly");
  sector_auth_a: assert property (idle_start ##0 (req_i.op == ckh_op_read) ##0 card_is_sector_i ##0
    !auth_ok_reg |=> refused_o && state_reg == st_idle)
    else $error("read went out without authentication");
  auth_card_a: assert property (idle_start ##0 (req_i.op == ckh_op_auth) ##0 !card_is_sector_i
    |=> refused_o)
    else $error("authenticate sent to a non-sector card");
  key_known_a: assert property (tx_valid_o && req_reg.op == ckh_op_auth && run_slot[6]
    |-> loaded_reg[run_slot[5:0]])
    else $error("authenticate refers to a key never stored");
  class_byte_a: assert property (tx_valid_o && idx_reg == 5'h00 |-> tx_data_o == `CKH_CLA)
    else $error("frame does not open with the class byte");
  auth_bytes_a: assert property (auth_b0_sent |-> tx_data_o == `CKH_AUTH_B0 ##1
    tx_data_o == `CKH_AUTH_B1)
    else $error("authenticate data header wrong");
  write_len_a: assert property (tx_valid_o && tx_last_o && req_reg.op == ckh_op_write
    |-> idx_reg == 5'(`CKH_HDR_BYTES + req_reg.len[4:0] - 5'h01) && req_reg.len != 8'h00)
    else $error("write frame length does not match Lc");
  wrong_le_a: assert property (retry_now |=> state_reg == st_send && tx_valid_o &&
    req_reg.len == $past(sw[7:0]) && !done_o)
    else $error("wrong-length answer not retried");
  status_a: assert property (state_reg == st_wait && sw_valid && !retry_now |=> done_o &&
    status_o == $past(sw) && !refused_o)
    else $error("status not reported from final bytes");

endmodule : ckh_host

`default_nettype wire

// [test/ckh_coupler.sv]
// behavioural coupler: takes command frames, keeps a key store, answers data then status
// assumes the host streams bytes on core_clk with valid/ready and takes replies without back-pressure
`timescale 1ns/1ps
`default_nettype none

module ckh_coupler #(
  parameter logic [7:0] MAX_BLK = 8'h3f
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic arst_n,
  // command bytes
  input wire logic tx_valid,
  input wire logic [7:0] tx_data,
  input wire logic tx_last,
  output logic tx_ready,
  // response bytes
  output var ckh_pkg::ckh_byte_s rx,
  // behaviour controls
  input wire logic slow_i,
  input wire logic nvm_i,
  input wire logic crypto_fail_i,
  input wire logic [7:0] blk_len_i
);
  import ckh_pkg::*;

  logic [7:0] cmd [0:31];
  logic [7:0] rsp [0:19];
  logic [63:0] keyed;
  logic [7:0] k, x;
  logic ph;
  int n, rn, ri, dly;

  // slow mode takes a byte only every other cycle
  assign tx_ready = ph | ~slow_i;

  function automatic logic idx_ok(input logic [7:0] loc, input logic [7:0] i);
    return loc == 8'h00 ? (i[7:2] == 6'h00 || i[7:2] == 6'h04) : (i[7:5] == 3'h0);
  endfunction : idx_ok

  task put(input logic [7:0] b);
    rsp[rn] = b;
    rn++;
  endtask : put

  task sw(input logic [15:0] w);
    put(w[15:8]);
    put(w[7:0]);
  endtask : sw

  task answer();
    rn = 0;
    k = cmd[8];
    x = cmd[9];
    case (cmd[1])
      8'h82: begin
        if (cmd[2] != 8'h00 && cmd[2] != 8'h20) sw(16'h6986);
        else if (cmd[2] == 8'h20 && !nvm_i) sw(16'h6987);
        else if (cmd[4] != 8'h06) sw(16'h6989);
        else if (!idx_ok(cmd[2], cmd[3])) sw(16'h6988);
        else begin
          keyed[{cmd[2][5], cmd[3][4:0]}] = 1'b1;
          sw(16'h9000);
        end
      end
      8'h86: begin
        if (k != 8'h60 && k != 8'h61 && k != 8'h00 && !(k == 8'h20 && nvm_i)) sw(16'h6986);
        else if (k[6] ? !(x < 8'h04 || (x[7:4] == 4'h2 && nvm_i)) : !idx_ok(k, x)) sw(16'h6988);
        else if (crypto_fail_i || !keyed[k[6] ? {x[5], k[0], x[3:0]} : {k[5], x[4:0]}]) sw(16'h6982);
        else sw(16'h9000);
      end
      8'hb0: begin
        if (cmd[2] != 8'h00 || cmd[3] > MAX_BLK) sw(16'h6a82);
        else if (cmd[4] != 8'h00 && cmd[4] < blk_len_i) sw({8'h6c, blk_len_i});
        else begin
          for (int j = 0; j < int'(blk_len_i); j++) put(cmd[3] + 8'(j));
          sw(cmd[4] > blk_len_i ? 16'h6282 : 16'h9000);
        end
      end
      8'hd6: sw(cmd[2] != 8'h00 || cmd[3] > MAX_BLK ? 16'h6a82 : 16'h9000);
      default: sw(16'h6981);
    endcase
  endtask : answer

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      n = 0;
      rn = 0;
      ri = 0;
      dly = 0;
      keyed = '0;
      ph <= 1'b0;
      rx <= '0;
    end else begin
      ph <= ~ph;
      if (ri < rn && dly == 0) begin
        rx <= {1'b1, rsp[ri], ri == rn - 1};
        ri++;
      end else begin
        rx <= {1'b0, ~rx.data, 1'b0};
        if (dly > 0) dly--;
      end
      if (tx_valid && tx_ready) begin
        cmd[n] = tx_data;
        n++;
        if (tx_last) begin
          n = 0;
          answer();
          ri = 0;
          dly = slow_i ? 3 : 0;
        end
      end
    end
  end
endmodule : ckh_coupler
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the card key host against the behavioural coupler
// assumes ckh_pkg and ckh_coupler are compiled first
`timescale 1ns/1ps
`default_nettype none

module tb;
  import ckh_pkg::*;
  logic core_clk, arst_n, start_i, card_is_sector_i, card_is_type2_i, card_new_i;
  ckh_req_s req_i;
  logic busy_o, done_o, refused_o, rd_valid_o, tx_valid_o, tx_last_o, tx_ready_i;
  logic [15:0] status_o, st;
  logic [7:0] rd_data_o, tx_data_o, blk_len;
  ckh_byte_s rx_i;
  logic slow, nvm, cfail, refd;
  logic [7:0] txq[$], rdq[$];
  int n_mismatch, cmp_count, cyc;

  ckh_host dut (.core_clk, .arst_n, .start_i, .req_i, .card_is_sector_i, .card_is_type2_i, .card_new_i,
    .busy_o, .done_o, .refused_o, .status_o, .rd_valid_o, .rd_data_o, .tx_valid_o, .tx_data_o, .tx_last_o,
    .tx_ready_i, .rx_i);
  ckh_coupler partner (.core_clk, .arst_n, .tx_valid(tx_valid_o), .tx_data(tx_data_o), .tx_last(tx_last_o),
    .tx_ready(tx_ready_i), .rx(rx_i), .slow_i(slow), .nvm_i(nvm), .crypto_fail_i(cfail), .blk_len_i(blk_len));

  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    cyc++;
    if (tx_valid_o && tx_ready_i) txq.push_back(tx_data_o);
    if (rd_valid_o) rdq.push_back(rd_data_o);
    if (cyc == 20000) begin
      n_mismatch++;
      close_out();
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic run(input ckh_op_e op, input logic [7:0] a, input logic [7:0] b, input logic [7:0] c);
    int t;
    txq.delete();
    rdq.delete();
    @(negedge core_clk);
    req_i = '{op, a, b, a, b, c, c, 48'ha1a2a3a4a5a6, 128'h000102030405060708090a0b0c0d0e0f};
    start_i = 1'b1;
    @(negedge core_clk);
    start_i = 1'b0;
    check({15'h0, busy_o ^ done_o}, 16'h0001);
    t = 0;
    while (done_o !== 1'b1 && t < 500) begin
      @(negedge core_clk);
      t++;
    end
    if (t == 500) n_mismatch++;
    st = status_o;
    refd = refused_o;
    check({15'h0, busy_o}, 16'h0000);
  endtask : run

  task automatic chk_tx(input logic [7:0] e[$]);
    check(16'(txq.size()), 16'(e.size()));
    foreach (e[i]) check({8'h00, txq[i]}, {8'h00, e[i]});
  endtask : chk_tx

  task automatic chk_rd(input int n, input logic [7:0] base);
    check(16'(rdq.size()), 16'(n));
    foreach (rdq[i]) check({8'h00, rdq[i]}, {8'h00, base + 8'(i)});
  endtask : chk_rd

  task automatic t_load();
    logic [31:0] cs [7];
    cs = '{32'h0000_9000, 32'h0010_9000, 32'h0005_6988, 32'h2000_6987, 32'h201f_9000, 32'h2020_6988, 32'h4000_6986};
    foreach (cs[i]) begin
      nvm = (i != 3);
      run(ckh_op_load, cs[i][31:24], cs[i][23:16], 8'h06);
      check(st, cs[i][15:0]);
    end
    run(ckh_op_load, 8'h00, 8'h01, 8'h06);
    chk_tx('{8'hff, 8'h82, 8'h00, 8'h01, 8'h06, 8'ha1, 8'ha2, 8'ha3, 8'ha4, 8'ha5, 8'ha6});
    check(16'(rdq.size()), 16'h0000);
    $display("test load done");
  endtask : t_load

  task automatic t_auth();
    logic [31:0] cs [6];
    slow = 1'b1;
    cs = '{32'h6200_6986, 32'h6005_6988, 32'h612f_9000, 32'h0010_9000, 32'h6100_9000, 32'h6000_9000};
    foreach (cs[i]) begin
      run(ckh_op_auth, 8'h04, cs[i][31:24], cs[i][23:16]);
      check(st, cs[i][15:0]);
    end
    chk_tx('{8'hff, 8'h86, 8'h00, 8'h00, 8'h05, 8'h01, 8'h00, 8'h04, 8'h60, 8'h00});
    run(ckh_op_auth, 8'h04, 8'h60, 8'h02);
    check({15'h0, refd}, 16'h0001);
    check(st, 16'h6985);
    check(16'(txq.size()), 16'h0000);
    cfail = 1'b1;
    run(ckh_op_auth, 8'h04, 8'h60, 8'h00);
    check(st, 16'h6982);
    cfail = 1'b0;
    slow = 1'b0;
    run(ckh_op_read, 8'h00, 8'h05, 8'h10);
    check({15'h0, refd}, 16'h0001);
    check(16'(txq.size()), 16'h0000);
    $display("test auth done");
  endtask : t_auth

  task automatic t_read();
    run(ckh_op_auth, 8'h04, 8'h60, 8'h00);
    run(ckh_op_read, 8'h00, 8'h05, 8'h10);
    check(st, 16'h9000);
    chk_rd(16, 8'h05);
    chk_tx('{8'hff, 8'hb0, 8'h00, 8'h05, 8'h10});
    run(ckh_op_read, 8'h00, 8'h07, 8'h00);
    check(st, 16'h9000);
    chk_rd(16, 8'h07);
    run(ckh_op_read, 8'h00, 8'h06, 8'h08);
    check(st, 16'h9000);
    chk_rd(16, 8'h06);
    chk_tx('{8'hff, 8'hb0, 8'h00, 8'h06, 8'h08, 8'hff, 8'hb0, 8'h00, 8'h06, 8'h10});
    run(ckh_op_read, 8'h00, 8'h08, 8'h10);
    check({15'h0, refd}, 16'h0001);
    $display("test read done");
  endtask : t_read

  task automatic t_write();
    logic [7:0] q[$];
    run(ckh_op_auth, 8'h04, 8'h60, 8'h00);
    run(ckh_op_write, 8'h00, 8'h06, 8'h10);
    check(st, 16'h9000);
    q = '{8'hff, 8'hd6, 8'h00, 8'h06, 8'h10};
    for (int i = 0; i < 16; i++) q.push_back(8'(i));
    chk_tx(q);
    run(ckh_op_write, 8'h00, 8'h06, 8'h04);
    check({15'h0, refd}, 16'h0001);
    card_is_sector_i = 1'b0;
    card_is_type2_i = 1'b1;
    blk_len = 8'h04;
    card_new_i = 1'b1;
    @(negedge core_clk);
    card_new_i = 1'b0;
    run(ckh_op_auth, 8'h04, 8'h60, 8'h00);
    check({15'h0, refd}, 16'h0001);
    check(16'(txq.size()), 16'h0000);
    run(ckh_op_write, 8'h00, 8'h03, 8'h04);
    check(st, 16'h9000);
    run(ckh_op_read, 8'h00, 8'h03, 8'h04);
    check(st, 16'h9000);
    chk_rd(4, 8'h03);
    run(ckh_op_read, 8'h00, 8'h03, 8'h08);
    check(st, 16'h6282);
    run(ckh_op_read, 8'h00, 8'h03, 8'h02);
    chk_rd(4, 8'h03);
    run(ckh_op_read, 8'h00, 8'hf0, 8'h04);
    check(st, 16'h6a82);
    run(ckh_op_write, 8'h00, 8'h03, 8'h10);
    check({15'h0, refd}, 16'h0001);
    $display("test write done");
  endtask : t_write

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : close_out

  initial begin
    arst_n = 1'b0;
    start_i = 1'b0;
    req_i = '0;
    card_is_sector_i = 1'b1;
    card_is_type2_i = 1'b0;
    card_new_i = 1'b0;
    slow = 1'b0;
    nvm = 1'b1;
    cfail = 1'b0;
    blk_len = 8'h10;
    n_mismatch = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (2) @(negedge core_clk);
    arst_n = 1'b1;
    t_load();
    t_auth();
    t_read();
    t_write();
    close_out();
  end
endmodule : tb
`default_nettype wire
